// ==== bench/gpp_pad_model.sv ====
module gpp_pad_model
    import gpp_pkg::*;
(
    // design drive
    input  wire logic [NUM_PINS-1:0] pin_o_i,
    input  wire logic [NUM_PINS-1:0] oe_n_i,
    // external drivers
    input  wire logic [NUM_PINS-1:0] ext_val_i,
    input  wire logic [NUM_PINS-1:0] ext_en_i,
    // resolved pad level
    output logic      [NUM_PINS-1:0] pad_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // board pull-ups, so a released line reads high rather than its last value
    assign pad_o = (~oe_n_i & pin_o_i) | (oe_n_i & ext_en_i & ext_val_i) | (oe_n_i & ~ext_en_i);
endmodule

// ==== bench/gpp_port_sva.sv ====
module gpp_port_sva
    import gpp_pkg::*;
(
    input wire logic                clk_i,
    input wire logic                reset_n_i,
    input wire logic                reg_grp_i,
    input wire logic [2:0]          reg_addr_i,
    input wire logic                reg_wr_i,
    input wire logic                reg_rd_i,
    input wire logic [GRP_W-1:0]    reg_wdata_i,
    input wire logic [GRP_W-1:0]    reg_rdata_o,
    input wire logic                reg_rvalid_o,
    input wire logic                timer_pin0_sel_i,
    input wire logic                timer_out_i,
    input wire logic [NUM_PINS-1:0] general_pin_i,
    input wire logic [NUM_PINS-1:0] general_pin_o,
    input wire logic [NUM_PINS-1:0] general_pin_oe_n_o,
    input wire logic                general_pin_irq_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);
    logic [NUM_PINS-1:0] pin_prev_q;
    logic [3:0]          quiet_q;
    // quiet_q counts cycles with no cause that could raise the interrupt
    always_ff @(posedge clk_i)
    begin
        pin_prev_q <= general_pin_i;
        quiet_q    <= (!reset_n_i || reg_wr_i || timer_pin0_sel_i || general_pin_i != pin_prev_q)
                      ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hf};
    end
    AST_RVALID: assert property (reg_rd_i |=> reg_rvalid_o)
        else $error("read without valid");
    AST_RV_ONE: assert property (!reg_rd_i |=> !reg_rvalid_o)
        else $error("valid without read");
    AST_RD_HOLD: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data moved");
    AST_RD_NONE: assert property (reg_rd_i && reg_addr_i > 3'h5 |=> reg_rdata_o == RDATA_NONE)
        else $error("unmapped read not zero");
    AST_TIMER: assert property (timer_pin0_sel_i |=>
        general_pin_o[0] == $past(timer_out_i) && !general_pin_oe_n_o[0])
        else $error("pin 0 not timer");
    AST_STILL: assert property (!$past(reg_wr_i, 2) |-> $stable(general_pin_o[15:1])
        && $stable(general_pin_oe_n_o[15:1]))
        else $error("pin drive moved without write");
    AST_IRQ_FALL: assert property ($fell(general_pin_irq_o) |-> $past(reg_rd_i, 2)
        && $past(reg_addr_i, 2) == REG_LEVEL)
        else $error("interrupt dropped without level read");
    AST_IRQ_QUIET: assert property (quiet_q > 4'h6 |-> !$rose(general_pin_irq_o))
        else $error("interrupt without cause");
    cover property ($rose(general_pin_irq_o));
    cover property (timer_pin0_sel_i);
    cover property (reg_rd_i && reg_addr_i == REG_LEVEL && reg_grp_i);
endmodule

bind gpp_port gpp_port_sva u_sva (.clk_i, .reset_n_i, .reg_grp_i, .reg_addr_i, .reg_wr_i,
    .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .timer_pin0_sel_i, .timer_out_i,
    .general_pin_i, .general_pin_o, .general_pin_oe_n_o, .general_pin_irq_o);

// ==== bench/multipurpose_pin_port_tb_top.sv ====
module multipurpose_pin_port_tb_top
    import gpp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic g; logic [2:0] a; logic [7:0] d; logic [7:0] e;} gpp_row_t;
    logic        clk_i     = 1'b0;
    logic        reset_n_i = 1'b0;
    logic        grp       = 1'b0;
    logic [2:0]  addr      = 3'h0;
    logic        wr        = 1'b0;
    logic        rd        = 1'b0;
    logic [7:0]  wdata     = 8'h00;
    logic        tsel      = 1'b0;
    logic        tout      = 1'b0;
    logic [15:0] ext_val   = 16'h0000;
    logic [15:0] ext_en    = 16'h0000;
    logic [7:0]  rdata;
    logic        rvalid;
    logic        irq;
    logic [15:0] pad, po, oe;
    int          n_errors  = 0;
    int          n_tests   = 0;
    int          cyc       = 0;
    // level reads 0xff after reset because the pads are pulled up
    logic [7:0]  rst_e [8] = '{RST_INT_EN, 8'hff, RST_TRISTATE, RST_INVERT, RST_DIRECTION,
                               RST_OPEN_DRN, RDATA_NONE, RDATA_NONE};
    gpp_row_t    rows [8]  = '{'{1'b0, REG_INT_EN, 8'h5a, 8'h5a}, '{1'b1, REG_INT_EN, 8'ha5, 8'ha5},
                               '{1'b0, REG_TRISTATE, 8'h3c, 8'h3c}, '{1'b1, REG_INVERT, 8'h0f, 8'h0f},
                               '{1'b0, REG_DIRECTION, 8'hc3, 8'hc3}, '{1'b1, REG_OPEN_DRN, 8'h81, 8'h81},
                               '{1'b0, 3'h6, 8'hff, RDATA_NONE}, '{1'b1, 3'h7, 8'h11, RDATA_NONE}};
    gpp_port uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .reg_grp_i(grp), .reg_addr_i(addr),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .reg_rvalid_o(rvalid), .timer_pin0_sel_i(tsel), .timer_out_i(tout),
        .general_pin_i(pad), .general_pin_o(po), .general_pin_oe_n_o(oe), .general_pin_irq_o(irq));
    gpp_pad_model pads (.pin_o_i(po), .oe_n_i(oe), .ext_val_i(ext_val), .ext_en_i(ext_en),
        .pad_o(pad));
    initial
    begin
        forever #10 clk_i = ~clk_i;
    end
    task automatic give_verdict();
        if (n_errors == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            n_errors++;
            give_verdict();
        end
    end
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic wr_reg(input logic g, input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_i);
        grp   <= g;
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk_i);
        wr    <= 1'b0;
    endtask
    task automatic rd_reg(input logic g, input logic [2:0] a);
        @(posedge clk_i);
        grp  <= g;
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_i);
        rd   <= 1'b0;
        #1;
        chk("rvalid", 16'h1, {15'h0, rvalid});
    endtask
    initial
    begin
        repeat (5) @(posedge clk_i);
        reset_n_i <= 1'b1;
        foreach (rows[i])
        begin
            wr_reg(rows[i].g, rows[i].a, rows[i].d);
            rd_reg(rows[i].g, rows[i].a);
            chk("row", {8'h0, rows[i].e}, {8'h0, rdata});
        end
        @(posedge clk_i);
        reset_n_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        reset_n_i <= 1'b1;
        for (int i = 0; i < 16; i++)
        begin
            rd_reg(i[3], i[2:0]);
            chk("reset", {8'h0, rst_e[i[2:0]]}, {8'h0, rdata});
        end
        chk("oe_rst", 16'hffff, oe);
        wr_reg(1'b0, REG_DIRECTION, 8'h00);
        settle(2);
        chk("po_rst", 16'h0000, po);
        chk("oe_out", 16'hff00, oe);
        wr_reg(1'b0, REG_LEVEL, 8'ha5);
        rd_reg(1'b0, REG_LEVEL);
        chk("lvl_out", 16'h00a5, {8'h0, rdata});
        chk("po_lvl", 16'h00a5, po);
        wr_reg(1'b0, REG_TRISTATE, 8'h0f);
        settle(2);
        chk("oe_tri", 16'hff0f, oe);
        wr_reg(1'b0, REG_TRISTATE, 8'h00);
        wr_reg(1'b0, REG_OPEN_DRN, 8'hf0);
        settle(2);
        chk("oe_od", 16'hffa0, oe);
        chk("po_od", 16'h0005, po);
        wr_reg(1'b0, REG_DIRECTION, 8'hff);
        settle(2);
        chk("oe_in", 16'hffff, oe);
        @(posedge clk_i);
        ext_en <= 16'h01c0;
        wr_reg(1'b0, REG_INT_EN, 8'h80);
        wr_reg(1'b1, REG_INT_EN, 8'h01);
        rd_reg(1'b0, REG_LEVEL);
        rd_reg(1'b1, REG_LEVEL);
        @(posedge clk_i);
        ext_val <= 16'h0040;
        settle(8);
        chk("irq_off", 16'h0, {15'h0, irq});
        @(posedge clk_i);
        ext_val <= 16'h00c0;
        settle(8);
        chk("irq_on", 16'h1, {15'h0, irq});
        rd_reg(1'b1, REG_LEVEL);
        settle(2);
        chk("irq_held", 16'h1, {15'h0, irq});
        rd_reg(1'b0, REG_LEVEL);
        settle(2);
        chk("irq_clr", 16'h0, {15'h0, irq});
        @(posedge clk_i);
        ext_val <= 16'h01c0;
        settle(8);
        chk("irq_hi", 16'h1, {15'h0, irq});
        rd_reg(1'b1, REG_LEVEL);
        wr_reg(1'b0, REG_INVERT, 8'h80);
        @(posedge clk_i);
        ext_val <= 16'h0140;
        settle(8);
        chk("irq_inv", 16'h1, {15'h0, irq});
        rd_reg(1'b0, REG_LEVEL);
        chk("lvl_inv", 16'h00ff, {8'h0, rdata});
        @(posedge clk_i);
        ext_en <= 16'h0140;
        wr_reg(1'b0, REG_DIRECTION, 8'h7f);
        for (int i = 0; i < 3; i++)
            wr_reg(1'b0, REG_LEVEL, {i[0], 7'h0});
        settle(8);
        chk("irq_out", 16'h0, {15'h0, irq});
        @(posedge clk_i);
        tsel <= 1'b1;
        tout <= 1'b1;
        settle(2);
        chk("tmr1", 16'h2, {14'h0, po[0], oe[0]});
        @(posedge clk_i);
        tout <= 1'b0;
        settle(2);
        chk("tmr0", 16'h0, {14'h0, po[0], oe[0]});
        give_verdict();
    end
endmodule

// ==== inc/gpp_pkg.sv ====
package gpp_pkg;

    // pin count and grouping: two sets of six byte-wide registers
    localparam int NUM_PINS = 16;
    localparam int GRP_W    = 8;
    localparam int NUM_GRPS = 2;

    // register index within one set
    localparam logic [2:0] REG_INT_EN    = 3'h0;
    localparam logic [2:0] REG_LEVEL     = 3'h1;
    localparam logic [2:0] REG_TRISTATE  = 3'h2;
    localparam logic [2:0] REG_INVERT    = 3'h3;
    localparam logic [2:0] REG_DIRECTION = 3'h4;
    localparam logic [2:0] REG_OPEN_DRN  = 3'h5;

    // reset values of one set (one byte)
    localparam logic [GRP_W-1:0] RST_INT_EN    = 8'h00;
    localparam logic [GRP_W-1:0] RST_LEVEL     = 8'h00;
    localparam logic [GRP_W-1:0] RST_TRISTATE  = 8'h00;
    localparam logic [GRP_W-1:0] RST_INVERT    = 8'h00;
    localparam logic [GRP_W-1:0] RST_DIRECTION = 8'hff;
    localparam logic [GRP_W-1:0] RST_OPEN_DRN  = 8'h00;
    localparam logic [GRP_W-1:0] RDATA_NONE    = 8'h00;

endpackage

// ==== verilog/gpp_pin_cell.sv ====
module gpp_pin_cell
    import gpp_pkg::*;
(
    // clock and reset
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    // synchronised pin level
    input  wire logic pin_sync_i,
    // per-pin settings
    input  wire logic dir_in_i,
    input  wire logic int_en_i,
    input  wire logic invert_i,
    input  wire logic level_i,
    input  wire logic tristate_i,
    input  wire logic open_drain_i,
    // timer takeover
    input  wire logic timer_sel_i,
    input  wire logic timer_val_i,
    // pad drive
    output logic      pin_o,
    output logic      pin_oe_n_o,
    // input status and edge event
    output logic      status_o,
    output logic      edge_o
);

    logic in_mode;
    logic prev_q;
    logic pin_d;
    logic oe_n_d;
    logic pin_q;
    logic oe_n_q;

    // the timer owner makes the pin an output, so it never interrupts
    assign in_mode  = dir_in_i & ~timer_sel_i;
    assign status_o = pin_sync_i ^ invert_i;

    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
            prev_q <= 1'b0;
        else
            prev_q <= status_o;
    end

    // rising edge of the inverted-or-not level: polarity set by invert bit
    assign edge_o = in_mode & int_en_i & status_o & ~prev_q;

    always_comb
    begin
        pin_d  = 1'b0;
        oe_n_d = 1'b1;
        if (timer_sel_i)
        begin
            pin_d  = timer_val_i;
            oe_n_d = 1'b0;
        end
        else if (dir_in_i)
        begin
            oe_n_d = 1'b1;
        end
        else if (tristate_i)
        begin
            oe_n_d = 1'b1;
        end
        else if (open_drain_i)
        begin
            oe_n_d = level_i;
        end
        else
        begin
            pin_d  = level_i;
            oe_n_d = 1'b0;
        end
    end

    // registered pad drive keeps the pin free of decode glitches
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            pin_q  <= 1'b0;
            oe_n_q <= 1'b1;
        end
        else
        begin
            pin_q  <= pin_d;
            oe_n_q <= oe_n_d;
        end
    end

    assign pin_o      = pin_q;
    assign pin_oe_n_o = oe_n_q;

endmodule

// ==== verilog/gpp_port.sv ====
// Contract
// - direction bit 1 makes a pin input, 0 output; reset makes all inputs.
// - inversion bit 1 inverts sampled input before status and interrupt use.
// - interrupt-enable bit 1 lets a pin interrupt; 0, the reset value, blocks.
// - interrupt-enable bit N governs pin N.
// - a pin set as output never raises an interrupt.
// - interrupts are edge sensed; inversion picks active-high or active-low.
// - all enabled pin interrupts OR into one request for UART channel 0.
// - reading the level register clears the pending pin interrupt; here a read clears only the eight pins of the set read.
// - level reads give input state; written level drives outputs; resets 0.
// - tri-state bit 1 floats an output pin; 0 drives the level.
// - open-drain bit 1 makes the output open-drain; 0, reset, drives normally.
// - open-drain setting is ignored while the pin is an input.
// - pin 0 given to timer follows timer output; all settings lose control.
// - registers form two sets of six, each set covering eight pins.
module gpp_port
    import gpp_pkg::*;
(
    // clock and reset
    input  wire logic                clk_i,
    input  wire logic                reset_n_i,
    // register port
    input  wire logic                reg_grp_i,
    input  wire logic [2:0]          reg_addr_i,
    input  wire logic                reg_wr_i,
    input  wire logic                reg_rd_i,
    input  wire logic [GRP_W-1:0]    reg_wdata_i,
    output logic      [GRP_W-1:0]    reg_rdata_o,
    output logic                     reg_rvalid_o,
    // timer takeover of pin 0
    input  wire logic                timer_pin0_sel_i,
    input  wire logic                timer_out_i,
    // pins
    input  wire logic [NUM_PINS-1:0] general_pin_i,
    output logic      [NUM_PINS-1:0] general_pin_o,
    output logic      [NUM_PINS-1:0] general_pin_oe_n_o,
    // combined pin interrupt toward uart channel 0 status
    output logic                     general_pin_irq_o
);

    logic [NUM_PINS-1:0] int_en_q;
    logic [NUM_PINS-1:0] level_q;
    logic [NUM_PINS-1:0] tristate_q;
    logic [NUM_PINS-1:0] invert_q;
    logic [NUM_PINS-1:0] dir_in_q;
    logic [NUM_PINS-1:0] open_drn_q;
    logic [NUM_PINS-1:0] pend_q;
    logic [NUM_PINS-1:0] pin_sync;
    logic [NUM_PINS-1:0] status;
    logic [NUM_PINS-1:0] edge_ev;
    logic [NUM_PINS-1:0] level_view;
    logic [NUM_PINS-1:0] rd_word;
    logic [NUM_PINS-1:0] grp_mask;
    logic [NUM_PINS-1:0] clr_mask;
    logic [GRP_W-1:0]    rdata_q;
    logic                rvalid_q;
    logic                irq_q;
    logic                lvl_read;
    logic                any_pend;
    logic [GRP_W-1:0]    rd_byte;

    // per-register write strobes
    logic                we_int_en;
    logic                we_level;
    logic                we_tristate;
    logic                we_invert;
    logic                we_direction;
    logic                we_open_drn;
    logic [NUM_PINS-1:0] tmr_sel;
    logic [NUM_PINS-1:0] tmr_val;

    // replace one byte-wide set of a sixteen-bit register
    function automatic logic [NUM_PINS-1:0] put_byte(
        input logic [NUM_PINS-1:0] old,
        input logic                grp,
        input logic [GRP_W-1:0]    d
    );
        logic [NUM_PINS-1:0] r;
        r = old;
        if (grp)
        begin
            r[NUM_PINS-1:GRP_W] = d;
        end
        else
        begin
            r[GRP_W-1:0] = d;
        end
        return r;
    endfunction

    // indices 6 and 7 decode to no strobe, so writes there are dropped
    assign we_int_en    = reg_wr_i && (reg_addr_i == REG_INT_EN);
    assign we_level     = reg_wr_i && (reg_addr_i == REG_LEVEL);
    assign we_tristate  = reg_wr_i && (reg_addr_i == REG_TRISTATE);
    assign we_invert    = reg_wr_i && (reg_addr_i == REG_INVERT);
    assign we_direction = reg_wr_i && (reg_addr_i == REG_DIRECTION);
    assign we_open_drn  = reg_wr_i && (reg_addr_i == REG_OPEN_DRN);

    // register writes, one set per access
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            int_en_q <= {NUM_GRPS{RST_INT_EN}};
        end
        else if (we_int_en)
        begin
            int_en_q <= put_byte(int_en_q, reg_grp_i, reg_wdata_i);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            level_q <= {NUM_GRPS{RST_LEVEL}};
        end
        else if (we_level)
        begin
            level_q <= put_byte(level_q, reg_grp_i, reg_wdata_i);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            tristate_q <= {NUM_GRPS{RST_TRISTATE}};
        end
        else if (we_tristate)
        begin
            tristate_q <= put_byte(tristate_q, reg_grp_i, reg_wdata_i);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            invert_q <= {NUM_GRPS{RST_INVERT}};
        end
        else if (we_invert)
        begin
            invert_q <= put_byte(invert_q, reg_grp_i, reg_wdata_i);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            dir_in_q <= {NUM_GRPS{RST_DIRECTION}};
        end
        else if (we_direction)
        begin
            dir_in_q <= put_byte(dir_in_q, reg_grp_i, reg_wdata_i);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            open_drn_q <= {NUM_GRPS{RST_OPEN_DRN}};
        end
        else if (we_open_drn)
        begin
            open_drn_q <= put_byte(open_drn_q, reg_grp_i, reg_wdata_i);
        end
    end

    gpp_sync u_sync (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .async_i   (general_pin_i),
        .sync_o    (pin_sync)
    );

    // only pin 0 can be handed to the timer; the other cells see it tied off
    assign tmr_sel = {{(NUM_PINS-1){1'b0}}, timer_pin0_sel_i};
    assign tmr_val = {{(NUM_PINS-1){1'b0}}, timer_out_i};

    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g++)
        begin : g_pin
            gpp_pin_cell u_cell (
                .clk_i        (clk_i),
                .reset_n_i    (reset_n_i),
                .pin_sync_i   (pin_sync[g]),
                .dir_in_i     (dir_in_q[g]),
                .int_en_i     (int_en_q[g]),
                .invert_i     (invert_q[g]),
                .level_i      (level_q[g]),
                .tristate_i   (tristate_q[g]),
                .open_drain_i (open_drn_q[g]),
                .timer_sel_i  (tmr_sel[g]),
                .timer_val_i  (tmr_val[g]),
                .pin_o        (general_pin_o[g]),
                .pin_oe_n_o   (general_pin_oe_n_o[g]),
                .status_o     (status[g]),
                .edge_o       (edge_ev[g])
            );
        end
    endgenerate

    // inputs show their (possibly inverted) state, outputs their written level
    assign level_view = (dir_in_q & status) | (~dir_in_q & level_q);

    // a level read clears only the pins of the set that was read
    assign lvl_read = reg_rd_i && (reg_addr_i == REG_LEVEL);
    assign grp_mask = {{GRP_W{reg_grp_i}}, {GRP_W{~reg_grp_i}}};
    assign clr_mask = lvl_read ? grp_mask : '0;

    // a new edge in the clearing cycle survives: set wins over clear
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            pend_q <= '0;
        end
        else
        begin
            pend_q <= (pend_q & ~clr_mask) | edge_ev;
        end
    end

    // registered so the request toward the uart status never glitches
    assign any_pend = |pend_q;

    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= any_pend;
        end
    end

    // index decode shared by both sets; 6 and 7 are legal and read zero
    always_comb
    begin
        rd_word = '0;
        unique case (reg_addr_i)
            REG_INT_EN:
            begin
                rd_word = int_en_q;
            end
            REG_LEVEL:
            begin
                rd_word = level_view;
            end
            REG_TRISTATE:
            begin
                rd_word = tristate_q;
            end
            REG_INVERT:
            begin
                rd_word = invert_q;
            end
            REG_DIRECTION:
            begin
                rd_word = dir_in_q;
            end
            REG_OPEN_DRN:
            begin
                rd_word = open_drn_q;
            end
            default:
            begin
                rd_word = '0;
            end
        endcase
    end

    assign rd_byte = reg_grp_i ? rd_word[NUM_PINS-1:GRP_W] : rd_word[GRP_W-1:0];

    // read data registered; unused indices answer zero
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            rdata_q  <= RDATA_NONE;
            rvalid_q <= 1'b0;
        end
        else
        begin
            rvalid_q <= reg_rd_i;
            if (reg_rd_i)
            begin
                rdata_q <= rd_byte;
            end
        end
    end

    assign reg_rdata_o       = rdata_q;
    assign reg_rvalid_o      = rvalid_q;
    assign general_pin_irq_o = irq_q;

endmodule

// ==== verilog/gpp_sync.sv ====
module gpp_sync
    import gpp_pkg::*;
(
    // clock and reset
    input  wire logic                clk_i,
    input  wire logic                reset_n_i,
    // asynchronous pins in, synchronised levels out
    input  wire logic [NUM_PINS-1:0] async_i,
    output logic      [NUM_PINS-1:0] sync_o
);

    logic [NUM_PINS-1:0] meta_q;
    logic [NUM_PINS-1:0] sync_q;

    // first stage feeds only the second stage
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;

endmodule
